// file: common/dlid_pkg.sv
// Shared constants and types for the debug link instruction decoder
package dlid_pkg;
  // ---------------------------------------------------------------
  // Opcodes in bits 7:5 of the instruction byte
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_DLOAD = 3'h0;
  localparam logic [2:0] OP_ILOAD = 3'h1;
  localparam logic [2:0] OP_DSTORE = 3'h2;
  localparam logic [2:0] OP_ISTORE = 3'h3;
  localparam logic [2:0] OP_CSLOAD = 3'h4;
  localparam logic [2:0] OP_REPEAT = 3'h5;
  localparam logic [2:0] OP_CSSTORE = 3'h6;
  localparam logic [2:0] OP_KEY = 3'h7;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int OPC_LSB = 5;
  localparam int SZA_LSB = 2;
  localparam int SZB_LSB = 0;
  localparam int SIB_BIT = 2;
  localparam int CSA_LSB = 0;
  // ---------------------------------------------------------------
  // Field codes and fixed values
  // ---------------------------------------------------------------
  localparam logic [1:0] SZ_RSVD = 2'h3;
  localparam logic [1:0] SZB_WORD = 2'h1;
  localparam logic [1:0] PTR_AT = 2'h0;
  localparam logic [1:0] PTR_INC = 2'h1;
  localparam logic [1:0] PTR_REG = 2'h2;
  localparam logic [4:0] KEY64_BYTES = 5'h08;
  localparam logic [4:0] KEY128_BYTES = 5'h10;
  localparam logic [7:0] ACK_BYTE = 8'h40;
  localparam logic [7:0] RPT_RST = 8'h00;
  // Sequencer states
  typedef enum logic [3:0] {S_IDLE, S_OPER, S_EXEC, S_BUS, S_CSRD, S_SEND, S_FIN, S_ERR} dlid_state_t;
endpackage

// file: design/dlid_fifo.sv
// Response byte FIFO between the sequencer and the physical layer
`timescale 1ns/10ps
module dlid_fifo #(
  parameter int W = 11,
  parameter int D = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  // Depth must be a power of two: pointers wrap naturally
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D]; // Storage words
  logic [AW:0] wp_r; // Write pointer, extra wrap bit
  logic [AW:0] rp_r; // Read pointer, extra wrap bit
  logic full;
  logic empty;
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = (wp_r == rp_r);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_r[rp_r[AW-1:0]];
  // Write side
  always_ff @(posedge i_ref_clk)
  begin
    if (i_in_valid && !full)
      mem_r[wp_r[AW-1:0]] <= i_in_data;
  end
  // Pointer update
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (i_in_valid && !full)
        wp_r <= wp_r + 1'b1;
      if (i_out_ready && !empty)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule // dlid_fifo

// file: design/dlid_core.sv
// Instruction decoder and data link sequencer of the debug port
// Function
// R1 - One-byte instruction, preceded by baud sync character
// R2 - Decode eight three-bit opcodes
// R3 - Address size selects one to three bytes
// R4 - Pointer field: at, post-increment, register itself
// R5 - Data size: byte or word
// R6 - Key size and key/info-block selector
// R7 - Address and data operands up to 32 bits
// R8 - Direct load returns data after guard time
// R9 - Repeated direct load resends address, no increment
// R10 - Pass request to bus layer, return data
// R11 - Direct store acks address, then write
// R12 - Indirect load via pointer, or returns pointer
// R13 - Debugger writes pointer before indirect load
// R14 - Pointer write acknowledged after address bytes
// R15 - Indirect store, optional post-increment, acknowledged
// R16 - Repeated store data sent after each ack
// R17 - Repeat runs count plus one times
// R18 - Idle bits before first turnaround byte
// R19 - Error state ignores all but break
// R20 - Reserved codes: no access, no ack
`timescale 1ns/10ps
module dlid_core import dlid_pkg::*; #(
  parameter int ADDR_W = 24,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_sync,
  input wire logic i_rx_break,
  input wire logic i_rx_error,
  input wire logic [2:0] i_guard_idle_count,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic [2:0] o_tx_idle_bits,
  input wire logic i_tx_ready,
  output logic o_bus_req,
  output logic o_bus_we,
  output logic o_bus_word,
  output logic [ADDR_W-1:0] o_bus_addr,
  output logic [15:0] o_bus_wdata,
  input wire logic i_bus_ack,
  input wire logic i_bus_err,
  input wire logic [15:0] i_bus_rdata,
  output logic o_cs_wr,
  output logic [3:0] o_cs_addr,
  output logic [7:0] o_cs_wdata,
  input wire logic [7:0] i_cs_rdata,
  input wire logic [127:0] i_sib_data,
  output logic o_key_done,
  output logic o_error
);
  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Byte count of a size code
  function automatic logic [4:0] f_nbytes(input logic [1:0] code);
    f_nbytes = 5'(code) + 5'h01;
  endfunction
  // Legal instruction check
  function automatic logic f_ok(input logic [7:0] b);
    logic [2:0] op;
    op = b[OPC_LSB +: 3];
    // R20 reserved codes
    case (op)
      // R3 address size 3 reserved, R4 pointer code 3 reserved, R5 data size 2/3 reserved
      OP_DLOAD, OP_DSTORE, OP_ILOAD, OP_ISTORE:
        f_ok = (b[SZA_LSB +: 2] != SZ_RSVD) && !b[SZB_LSB + 1];
      // R6 key size above 128 bits reserved
      OP_REPEAT, OP_KEY:
        f_ok = !b[SZB_LSB + 1];
      default:
        f_ok = 1'b1;
    endcase
  endfunction
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dlid_state_t st_r; // Sequencer state
  logic [7:0] ins_r; // Current instruction
  logic [4:0] cnt_r; // Byte counter
  logic [4:0] len_r; // Bytes in this phase
  logic [31:0] opnd_r; // Received operand, little endian
  logic [31:0] data_r; // Bytes to send
  logic [ADDR_W-1:0] ptr_r; // Address pointer
  logic [7:0] rpt_r; // Repeats still to run
  logic sync_r; // Sync seen, instruction may follow
  logic replay_r; // Rerun ins_r without sync
  logic phase_r; // Store: 0 address, 1 data
  logic sib_r; // Send source is the info block
  logic dir_tx_r; // Link already turned to transmit
  logic bus_req_r;
  logic bus_we_r;
  logic bus_word_r;
  logic [ADDR_W-1:0] bus_addr_r;
  logic [15:0] bus_wdata_r;
  logic cs_wr_r;
  logic [3:0] cs_addr_r;
  logic [7:0] cs_wdata_r;
  logic key_done_r;
  logic error_r;
  // ---------------------------------------------------------------
  // Field views and stream glue
  // ---------------------------------------------------------------
  logic [2:0] opc;
  logic [1:0] fa;
  logic [1:0] fb;
  logic dec_go;
  logic [7:0] dec_b;
  logic fifo_rdy;
  logic push;
  logic [7:0] tx_byte;
  logic [2:0] tx_idle;
  assign opc = ins_r[OPC_LSB +: 3];
  assign fa = ins_r[SZA_LSB +: 2];
  assign fb = ins_r[SZB_LSB +: 2];
  // R1 new instruction only after a sync character
  assign dec_go = (st_r == S_IDLE) && (replay_r || (i_rx_valid && sync_r));
  assign dec_b = replay_r ? ins_r : i_rx_data;
  assign push = (st_r == S_SEND) && fifo_rdy;
  assign tx_byte = sib_r ? i_sib_data[{cnt_r[3:0], 3'h0} +: 8] : data_r[{cnt_r[1:0], 3'h0} +: 8];
  // R18 guard idle bits only on first byte after turnaround
  assign tx_idle = dir_tx_r ? 3'h0 : i_guard_idle_count;
  // ---------------------------------------------------------------
  // Response FIFO; a full FIFO holds the sequencer in S_SEND
  // ---------------------------------------------------------------
  dlid_fifo #(
    .W(11),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(st_r == S_SEND),
    .o_in_ready(fifo_rdy),
    .i_in_data({tx_idle, tx_byte}),
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready),
    .o_out_data({o_tx_idle_bits, o_tx_data})
  );
  // ---------------------------------------------------------------
  // Sync flag and link direction
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || i_rx_break)
      sync_r <= 1'b0;
    else if (i_rx_sync)
      sync_r <= 1'b1;
    else if (dec_go && !replay_r)
      sync_r <= 1'b0;
  end
  // Received traffic turns the link round again
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || i_rx_valid || i_rx_sync)
      dir_tx_r <= 1'b0;
    else if (push)
      dir_tx_r <= 1'b1;
  end
  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    cs_wr_r <= 1'b0;
    key_done_r <= 1'b0;
    if (i_rst)
    begin
      st_r <= S_IDLE;
      ins_r <= 8'h00;
      cnt_r <= 5'h00;
      len_r <= 5'h00;
      opnd_r <= 32'h0000_0000;
      data_r <= 32'h0000_0000;
      ptr_r <= '0;
      rpt_r <= RPT_RST;
      replay_r <= 1'b0;
      phase_r <= 1'b0;
      sib_r <= 1'b0;
      bus_req_r <= 1'b0;
      bus_we_r <= 1'b0;
      bus_word_r <= 1'b0;
      bus_addr_r <= '0;
      bus_wdata_r <= 16'h0000;
      cs_addr_r <= 4'h0;
      cs_wdata_r <= 8'h00;
      error_r <= 1'b0;
    end
    else if (i_rx_break)
    begin
      // R17 break aborts repeat; R19 break leaves error
      st_r <= S_IDLE;
      rpt_r <= RPT_RST;
      replay_r <= 1'b0;
      bus_req_r <= 1'b0;
      error_r <= 1'b0;
    end
    else if (i_rx_error && st_r != S_ERR)
    begin
      // R19 link error enters error state
      st_r <= S_ERR;
      bus_req_r <= 1'b0;
      error_r <= 1'b1;
    end
    else
    begin
      case (st_r)
        S_IDLE:
        begin
          if (dec_go)
          begin
            ins_r <= dec_b;
            replay_r <= 1'b0;
            cnt_r <= 5'h00;
            opnd_r <= 32'h0000_0000;
            sib_r <= 1'b0;
            phase_r <= 1'b0;
            if (!f_ok(dec_b))
            begin
              // R20 invalid instruction: no access, no ack
              st_r <= S_ERR;
              error_r <= 1'b1;
            end
            else
            begin
              // R2 opcode dispatch
              case (dec_b[OPC_LSB +: 3])
                // R3 address bytes per size code
                OP_DLOAD, OP_DSTORE:
                begin
                  len_r <= f_nbytes(dec_b[SZA_LSB +: 2]);
                  st_r <= S_OPER;
                end
                OP_ILOAD:
                begin
                  len_r <= f_nbytes(dec_b[SZB_LSB +: 2]);
                  if (dec_b[SZA_LSB +: 2] == PTR_REG)
                  begin
                    // R12 pointer read back
                    data_r <= 32'(ptr_r);
                    st_r <= S_SEND;
                  end
                  else
                  begin
                    // R12 R10 read through pointer
                    bus_req_r <= 1'b1;
                    bus_we_r <= 1'b0;
                    bus_word_r <= (dec_b[SZB_LSB +: 2] == SZB_WORD);
                    bus_addr_r <= ptr_r;
                    st_r <= S_BUS;
                  end
                end
                OP_ISTORE:
                begin
                  // R14 pointer write takes size-field bytes
                  len_r <= f_nbytes(dec_b[SZB_LSB +: 2]);
                  phase_r <= (dec_b[SZA_LSB +: 2] != PTR_REG);
                  st_r <= S_OPER;
                end
                OP_CSLOAD:
                begin
                  cs_addr_r <= dec_b[CSA_LSB +: 4];
                  st_r <= S_CSRD;
                end
                OP_KEY:
                begin
                  // R6 key length and direction
                  len_r <= dec_b[SZB_LSB] ? KEY128_BYTES : KEY64_BYTES;
                  sib_r <= dec_b[SIB_BIT];
                  st_r <= dec_b[SIB_BIT] ? S_SEND : S_OPER;
                end
                default:
                begin
                  // Repeat count and control store take one byte
                  len_r <= 5'h01;
                  st_r <= S_OPER;
                end
              endcase
            end
          end
        end
        S_OPER:
        begin
          if (i_rx_valid)
          begin
            // R7 operand of up to four bytes, low byte first
            opnd_r[{cnt_r[1:0], 3'h0} +: 8] <= i_rx_data;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == len_r - 5'h01)
              st_r <= S_EXEC;
          end
        end
        S_EXEC:
        begin
          cnt_r <= 5'h00;
          len_r <= 5'h01;
          data_r <= 32'(ACK_BYTE);
          st_r <= S_FIN;
          case (opc)
            OP_DLOAD:
            begin
              // R8 R9 read at the freshly sent address
              bus_req_r <= 1'b1;
              bus_we_r <= 1'b0;
              bus_word_r <= (fb == SZB_WORD);
              bus_addr_r <= opnd_r[ADDR_W-1:0];
              st_r <= S_BUS;
            end
            OP_DSTORE, OP_ISTORE:
            begin
              if (!phase_r && opc == OP_ISTORE)
              begin
                // R14 pointer written, then ack
                ptr_r <= opnd_r[ADDR_W-1:0];
                st_r <= S_SEND;
              end
              else if (!phase_r)
              begin
                // R11 address taken, ack it
                bus_addr_r <= opnd_r[ADDR_W-1:0];
                st_r <= S_SEND;
              end
              else
              begin
                // R11 R15 data write request
                bus_req_r <= 1'b1;
                bus_we_r <= 1'b1;
                bus_word_r <= (fb == SZB_WORD);
                bus_wdata_r <= opnd_r[15:0];
                if (opc == OP_ISTORE)
                  bus_addr_r <= ptr_r;
                st_r <= S_BUS;
              end
            end
            OP_REPEAT:
              rpt_r <= opnd_r[7:0];
            OP_CSSTORE:
            begin
              // Control store: no response byte
              cs_wr_r <= 1'b1;
              cs_addr_r <= ins_r[CSA_LSB +: 4];
              cs_wdata_r <= opnd_r[7:0];
            end
            default:
              key_done_r <= 1'b1;
          endcase
        end
        S_BUS:
        begin
          if (i_bus_ack)
          begin
            bus_req_r <= 1'b0;
            cnt_r <= 5'h00;
            if (i_bus_err)
            begin
              // R19 access error
              st_r <= S_ERR;
              error_r <= 1'b1;
            end
            else
            begin
              // R10 buffered read data, or write ack
              data_r <= bus_we_r ? 32'(ACK_BYTE) : 32'(i_bus_rdata);
              len_r <= bus_we_r ? 5'h01 : f_nbytes(fb);
              st_r <= S_SEND;
              // R15 post-increment by data size
              if (opc != OP_DLOAD && opc != OP_DSTORE && fa == PTR_INC)
                ptr_r <= ptr_r + ADDR_W'(f_nbytes(fb));
            end
          end
        end
        S_CSRD:
        begin
          data_r <= 32'(i_cs_rdata);
          len_r <= 5'h01;
          cnt_r <= 5'h00;
          st_r <= S_SEND;
        end
        S_SEND:
        begin
          // R8 bytes leave in order, guard marked on first
          if (fifo_rdy)
          begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == len_r - 5'h01)
              st_r <= S_FIN;
          end
        end
        S_FIN:
        begin
          cnt_r <= 5'h00;
          opnd_r <= 32'h0000_0000;
          if (opc == OP_DSTORE && !phase_r)
          begin
            // R11 now collect the data bytes
            phase_r <= 1'b1;
            len_r <= f_nbytes(fb);
            st_r <= S_OPER;
          end
          else if (opc != OP_REPEAT && rpt_r != RPT_RST)
          begin
            // R17 R9 rerun whole instruction, address resent
            rpt_r <= rpt_r - 8'h01;
            replay_r <= 1'b1;
            st_r <= S_IDLE;
          end
          else
            st_r <= S_IDLE;
        end
        default:
          // R19 hold until break
          st_r <= S_ERR;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Output drive
  // ---------------------------------------------------------------
  assign o_bus_req = bus_req_r;
  assign o_bus_we = bus_we_r;
  assign o_bus_word = bus_word_r;
  assign o_bus_addr = bus_addr_r;
  assign o_bus_wdata = bus_wdata_r;
  assign o_cs_wr = cs_wr_r;
  assign o_cs_addr = cs_addr_r;
  assign o_cs_wdata = cs_wdata_r;
  assign o_key_done = key_done_r;
  assign o_error = error_r;
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic quiet;
  assign quiet = !i_rx_break && !i_rx_error;
  property p_need_sync;
    (st_r == S_IDLE && !replay_r && !sync_r && quiet) |=> st_r == S_IDLE;
  endproperty
  a_need_sync: assert property (p_need_sync) else $error("instruction taken without sync"); // R1
  property p_rsvd;
    (dec_go && !f_ok(dec_b) && quiet) |=> (st_r == S_ERR && !o_bus_req) ##1 !o_tx_valid;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved instruction not refused"); // R20
  property p_err_hold;
    (st_r == S_ERR && !i_rx_break) |=> st_r == S_ERR && o_error;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error state left without break"); // R19
  property p_bus_hold;
    (o_bus_req && !i_bus_ack && quiet) |=> o_bus_req && $stable(o_bus_addr);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus request dropped early"); // R10
  property p_guard;
    (push && !dir_tx_r) |-> tx_idle == i_guard_idle_count ##1 dir_tx_r || i_rx_valid || i_rx_sync;
  endproperty
  a_guard: assert property (p_guard) else $error("guard bits missing on turnaround"); // R18
  property p_postinc;
    (st_r == S_BUS && i_bus_ack && !i_bus_err && quiet && opc == OP_ISTORE && fa == PTR_INC)
      |=> ptr_r == $past(ptr_r) + ADDR_W'(f_nbytes(fb));
  endproperty
  a_postinc: assert property (p_postinc) else $error("pointer not advanced"); // R15
  sequence s_resend;
    st_r == S_IDLE && replay_r ##1 st_r == S_OPER && len_r == f_nbytes(fa);
  endsequence
  property p_resend;
    (st_r == S_FIN && opc == OP_DLOAD && rpt_r != RPT_RST && quiet ##1 quiet) |-> s_resend;
  endproperty
  a_resend: assert property (p_resend) else $error("repeated load skipped address"); // R9
  property p_rpt;
    (st_r == S_FIN && opc != OP_REPEAT && opc != OP_DSTORE && rpt_r != RPT_RST && quiet)
      |=> rpt_r == $past(rpt_r) - 8'h01;
  endproperty
  a_rpt: assert property (p_rpt) else $error("repeat count not stepped"); // R17
  sequence s_wr_pulse;
    o_cs_wr ##1 !o_cs_wr;
  endsequence
  property p_cs_store;
    (st_r == S_EXEC && opc == OP_CSSTORE && quiet) |=> s_wr_pulse;
  endproperty
  a_cs_store: assert property (p_cs_store) else $error("control store not one pulse"); // R2
endmodule // dlid_core

// file: verification/dlid_bus_mem.sv
// Bus memory model answering the sequencer's bus requests
`timescale 1ns/10ps
module dlid_bus_mem (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic i_word,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [3:0] i_lat,
  output logic o_ack,
  output logic [15:0] o_rdata
);
  logic [7:0] mem [0:255]; // Only low address byte decoded
  logic [3:0] wait_r; // Cycles waited on this request
  logic done_r; // Answered, wait for request to drop
  always_ff @(posedge i_ref_clk)
  begin
    o_ack <= 1'b0;
    // Data released outside the ack cycle, so never a stale match
    o_rdata <= ~o_rdata;
    if (i_rst || !i_req)
    begin
      wait_r <= 4'h0;
      done_r <= 1'b0;
    end
    else if (!done_r && wait_r < i_lat)
      wait_r <= wait_r + 4'h1;
    else if (!done_r)
    begin
      o_ack <= 1'b1;
      done_r <= 1'b1;
      o_rdata <= {mem[i_addr[7:0] + 8'h01], mem[i_addr[7:0]]};
      if (i_we)
        mem[i_addr[7:0]] <= i_wdata[7:0];
      if (i_we && i_word)
        mem[i_addr[7:0] + 8'h01] <= i_wdata[15:8];
    end
  end
endmodule // dlid_bus_mem

// file: verification/tb_top.sv
// Self-checking bench for the debug link instruction decoder
`timescale 1ns/10ps
module tb_top import dlid_pkg::*;;
  localparam logic [2:0] GUARD = 3'h2; // Idle bits before a reply
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_v = 1'b0;
  logic [7:0] rx_d = 8'h00;
  logic sync = 1'b0;
  logic brk = 1'b0;
  logic rxe = 1'b0; // Link error pulse
  logic berr = 1'b0; // Bus error returned with ack
  logic txr = 1'b0;
  logic [3:0] lat = 4'h0;
  logic tx_v, req, we, word, ack, err;
  logic [7:0] tx_d;
  logic [2:0] tx_idle;
  logic [23:0] addr;
  logic [15:0] wdata, rdata;
  int bad_count = 0;
  int cmp_count = 0;
  logic cs_wr, key_done;
  logic [3:0] cs_addr;
  logic [7:0] cs_wdata;
  logic [11:0] cs_cap = 12'h000; // Last control store seen
  logic [3:0] pulses = 4'h0; // Store and key-done strobes seen
  // Catch one-cycle strobes while they stand; a long strobe counts once per cycle
  always @(posedge clk)
  begin
    if (cs_wr)
      cs_cap <= {cs_addr, cs_wdata};
    if (cs_wr || key_done)
      pulses <= pulses + 4'h1;
  end
  // 125 MHz clock
  always #4 clk = ~clk;
  dlid_core dlid_core_i (.i_ref_clk(clk), .i_rst(rst), .i_rx_valid(rx_v), .i_rx_data(rx_d),
    .i_rx_sync(sync), .i_rx_break(brk), .i_rx_error(rxe), .i_guard_idle_count(GUARD),
    .o_tx_valid(tx_v), .o_tx_data(tx_d), .o_tx_idle_bits(tx_idle), .i_tx_ready(txr),
    .o_bus_req(req), .o_bus_we(we), .o_bus_word(word), .o_bus_addr(addr), .o_bus_wdata(wdata),
    .i_bus_ack(ack), .i_bus_err(berr), .i_bus_rdata(rdata), .o_cs_wr(cs_wr), .o_cs_addr(cs_addr),
    .o_cs_wdata(cs_wdata), .i_cs_rdata({4'hA, cs_addr}), .i_sib_data(128'h0F0E0D0C0B0A09080706050403020100),
    .o_key_done(key_done), .o_error(err));
  dlid_bus_mem dlid_bus_mem_i (.i_ref_clk(clk), .i_rst(rst), .i_req(req), .i_we(we), .i_word(word),
    .i_addr(addr), .i_wdata(wdata), .i_lat(lat), .o_ack(ack), .o_rdata(rdata));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One received byte, spaced so the sequencer never drops it
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_v <= 1'b1;
    rx_d <= b;
    @(posedge clk);
    rx_v <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // sync character ahead of each instruction
  task automatic op(input logic [7:0] b);
    @(posedge clk);
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    send(b);
  endtask
  // Wait for a reply byte, judge it, pop it
  task automatic get(input logic [7:0] d, input logic [2:0] g);
    int n;
    n = 0;
    @(posedge clk);
    while (tx_v !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    // A stale head byte must not pass for a reply
    chk({15'h0000, tx_v}, 16'h0001);
    chk({8'h00, tx_d}, {8'h00, d});
    chk({13'h0000, tx_idle}, {13'h0000, g});
    txr <= 1'b1;
    @(posedge clk);
    txr <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_direct();
    lat <= 4'h5;
    op({OP_DSTORE, 5'h00});
    send(8'h12);
    get(ACK_BYTE, GUARD);
    send(8'hA5);
    get(ACK_BYTE, GUARD);
    chk({8'h00, dlid_bus_mem_i.mem[8'h12]}, 16'h00A5);
    op({OP_DLOAD, 5'h00});
    send(8'h12);
    get(8'hA5, GUARD);
    lat <= 4'h0;
  endtask
  task automatic t_ptr();
    op({OP_ISTORE, 1'b0, PTR_REG, 2'h0});
    send(8'h20);
    get(ACK_BYTE, GUARD);
    op({OP_ISTORE, 1'b0, PTR_INC, SZB_WORD});
    send(8'h34);
    send(8'h12);
    get(ACK_BYTE, GUARD);
    chk({dlid_bus_mem_i.mem[8'h21], dlid_bus_mem_i.mem[8'h20]}, 16'h1234);
    // Post-increment by the word size shows in the pointer readback
    op({OP_ILOAD, 1'b0, PTR_REG, 2'h0});
    get(8'h22, GUARD);
    op({OP_ISTORE, 1'b0, PTR_REG, 2'h0});
    send(8'h20);
    get(ACK_BYTE, GUARD);
    op({OP_ILOAD, 1'b0, PTR_AT, SZB_WORD});
    get(8'h34, GUARD);
    get(8'h12, 3'h0);
  endtask
  // Direct load repeated twice, each with its own address
  task automatic t_rpt();
    op({OP_REPEAT, 5'h00});
    send(8'h01);
    op({OP_DLOAD, 5'h00});
    send(8'h12);
    get(8'hA5, GUARD);
    send(8'h20);
    get(8'h34, GUARD);
    repeat (30) @(posedge clk);
    chk({15'h0000, tx_v}, 16'h0000);
  endtask
  // Pointer preset, then a repeated post-increment byte store
  task automatic t_rps();
    op({OP_ISTORE, 1'b0, PTR_REG, 2'h0});
    send(8'h30);
    get(ACK_BYTE, GUARD);
    op({OP_REPEAT, 5'h00});
    send(8'h01);
    op({OP_ISTORE, 1'b0, PTR_INC, 2'h0});
    send(8'h11);
    get(ACK_BYTE, GUARD);
    send(8'h22);
    get(ACK_BYTE, GUARD);
    chk({dlid_bus_mem_i.mem[8'h31], dlid_bus_mem_i.mem[8'h30]}, 16'h2211);
  endtask
  // Control store strobe, control load readback, key receive
  task automatic t_cs();
    op({OP_CSSTORE, 1'b0, 4'h3});
    send(8'h77);
    chk({4'h0, cs_cap}, 16'h0377);
    op({OP_CSLOAD, 1'b0, 4'h3});
    get(8'hA3, GUARD);
    op({OP_KEY, 2'h0, 1'b0, 2'h0});
    for (int k = 0; k < 8; k++)
      send(8'h00);
    // One store strobe, one key strobe, no reply to a key
    chk({11'h000, pulses, tx_v}, 16'h0004);
  endtask
  // Info block queues eight bytes in the buffer while the far side stalls
  task automatic t_sib();
    op({OP_KEY, 2'h0, 1'b1, 2'h0});
    repeat (40) @(posedge clk);
    chk({15'h0000, tx_v}, 16'h0001);
    for (int k = 0; k < 8; k++)
      get(k[7:0], (k == 0) ? GUARD : 3'h0);
  endtask
  task automatic t_rsvd();
    op({OP_DLOAD, 1'b0, SZ_RSVD, 2'h0});
    repeat (10) @(posedge clk);
    chk({15'h0000, err}, 16'h0001);
    op({OP_DLOAD, 5'h00});
    send(8'h12);
    repeat (20) @(posedge clk);
    chk({14'h0000, req, tx_v}, 16'h0000);
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    repeat (3) @(posedge clk);
    chk({15'h0000, err}, 16'h0000);
    op({OP_DLOAD, 5'h00});
    send(8'h12);
    get(8'hA5, GUARD);
    // Link error and bus error both lock the sequencer
    rxe <= 1'b1;
    @(posedge clk);
    rxe <= 1'b0;
    repeat (3) @(posedge clk);
    chk({15'h0000, err}, 16'h0001);
    brk <= 1'b1;
    berr <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    op({OP_DLOAD, 5'h00});
    send(8'h12);
    repeat (5) @(posedge clk);
    chk({14'h0000, err, tx_v}, 16'h0002);
    berr <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_direct();
    t_ptr();
    t_rpt();
    t_rps();
    t_sib();
    t_cs();
    t_rsvd();
    report_and_stop();
  end
endmodule // tb_top
